// ===== verilog/psp_regs.svh
// constants of the pipelined burst sram port: widths, encodings, timing
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// address and word geometry of the x36 organisation
`define PSP_ADDR_W 20
`define PSP_DEPTH 1048576
`define PSP_LANES 4
`define PSP_BYTE_W 8
`define PSP_LANE_W 9
`define PSP_DATA_W 32
`define PSP_WORD_W 36

// burst counter covers the two lowest address bits
`define PSP_BURST_W 2
`define PSP_BEAT_ONE 2'h1
`define PSP_BEAT_ZERO 2'h0

// sleep entry and exit, in clock cycles
`define PSP_SLEEP_CYCLES 2
`define PSP_SLEEP_CNT_W 2
`define PSP_SLEEP_LAST 2'h1

`endif

// ===== verilog/psp_pkg.sv
// types shared by the pipelined burst sram port
`default_nettype none

package psp_pkg;

	// sleep sequencer states
	typedef enum logic [1:0] {
		PSP_AWAKE,
		PSP_ENTERING,
		PSP_ASLEEP,
		PSP_WAKING
	} psp_sleep_t;

	// burst order as sampled from the order select pin
	typedef enum logic {
		PSP_ORDER_LINEAR,
		PSP_ORDER_INTERLEAVED
	} psp_order_t;

endpackage

`default_nettype wire

// ===== verilog/psp_mem_if.sv
// connection between the port control and its storage array
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

interface psp_mem_if;
	logic rd_en; // registered read, held while low
	logic [`PSP_ADDR_W-1:0] rd_addr;
	logic [`PSP_WORD_W-1:0] rdata; // output register of the array
	logic wr_en; // write beat completes this edge
	logic [`PSP_ADDR_W-1:0] wr_addr;
	logic [`PSP_LANES-1:0] lane_en; // active-high byte lane enables
	logic [`PSP_WORD_W-1:0] wdata;

	modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, lane_en, wdata,
		input rdata);
	modport mem (input rd_en, rd_addr, wr_en, wr_addr, lane_en, wdata,
		output rdata);
endinterface

`default_nettype wire

// ===== verilog/psp_core_mem.sv
// byte-lane storage array with a registered read port
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module psp_core_mem (
	input wire logic core_clk,
	psp_mem_if.mem port
);
	import psp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// one array per byte lane so unselected lanes are never touched
	genvar i;
	generate
		for (i = 0; i < `PSP_LANES; i = i + 1) begin : g_lane
			logic [`PSP_LANE_W-1:0] cells [0:`PSP_DEPTH-1];
			logic [`PSP_LANE_W-1:0] rd_lane; // lane slice of the output register
			logic [`PSP_LANE_W-1:0] next_rd_lane;
			logic hit; // write to the same word in this edge

			// write-first forwarding: a read issued one cycle after a write
			// start meets that write's data edge, so it must see new bytes
			always_comb begin
				hit = port.wr_en && port.lane_en[i] &&
					(port.wr_addr == port.rd_addr);
				next_rd_lane = rd_lane;
				if (port.rd_en) begin
					next_rd_lane = hit ?
						port.wdata[i*`PSP_LANE_W +: `PSP_LANE_W] :
						cells[port.rd_addr];
				end
			end

			// array update and output register
			always_ff @(posedge core_clk) begin
				if (port.wr_en && port.lane_en[i]) begin
					cells[port.wr_addr] <=
						port.wdata[i*`PSP_LANE_W +: `PSP_LANE_W];
				end
				rd_lane <= next_rd_lane;
			end

			assign port.rdata[i*`PSP_LANE_W +: `PSP_LANE_W] = rd_lane;
		end
	endgenerate

endmodule

`default_nettype wire

// ===== verilog/psp_sram_port.sv
// synchronous port logic of a pipelined burst sram without turnaround
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module psp_sram_port (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clock_qualifier_n,
	input wire logic advance_or_load,
	input wire logic write_select_n,
	input wire logic [`PSP_LANES-1:0] byte_lane_write_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic output_enable_n,
	input wire logic burst_order_interleaved,
	input wire logic sleep_request,
	input wire logic [`PSP_ADDR_W-1:0] address,
	input wire logic [`PSP_DATA_W-1:0] data_lanes_in,
	input wire logic [`PSP_LANES-1:0] parity_lanes_in,
	output logic [`PSP_DATA_W-1:0] data_lanes_out,
	output logic [`PSP_LANES-1:0] parity_lanes_out,
	output logic lanes_oe,
	output logic asleep
);
	import psp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	psp_mem_if mem_port ();

	// burst context
	logic burst_active; // last load started an access, not a deselect
	logic next_burst_active;
	logic burst_write; // direction latched at burst start
	logic next_burst_write;
	logic [`PSP_ADDR_W-1:0] burst_base; // loaded address
	logic [`PSP_ADDR_W-1:0] next_burst_base;
	logic [`PSP_BURST_W-1:0] burst_beat; // beats advanced since load
	logic [`PSP_BURST_W-1:0] next_burst_beat;
	psp_order_t burst_order; // order in force for this burst
	psp_order_t next_burst_order;

	// stage one: operation captured at the edge it was presented
	logic s1_valid;
	logic next_s1_valid;
	logic s1_write;
	logic next_s1_write;
	logic [`PSP_ADDR_W-1:0] s1_addr;
	logic [`PSP_ADDR_W-1:0] next_s1_addr;
	logic [`PSP_LANES-1:0] s1_bw_n; // byte selects as presented
	logic [`PSP_LANES-1:0] next_s1_bw_n;

	// stage two: write waiting for its data edge
	logic s2_valid;
	logic next_s2_valid;
	logic [`PSP_ADDR_W-1:0] s2_addr;
	logic [`PSP_ADDR_W-1:0] next_s2_addr;
	logic [`PSP_LANES-1:0] s2_bw_n;
	logic [`PSP_LANES-1:0] next_s2_bw_n;

	// read data valid in the output register
	logic read_out;
	logic next_read_out;

	// sleep sequencer
	psp_sleep_t sleep_state;
	psp_sleep_t next_sleep_state;
	logic [`PSP_SLEEP_CNT_W-1:0] sleep_cnt;
	logic [`PSP_SLEEP_CNT_W-1:0] next_sleep_cnt;

	// combinational helpers
	logic qualified; // this edge counts
	logic selected; // all three chip selects active
	logic awake; // normal operation allowed
	logic [`PSP_BURST_W-1:0] adv_beat; // beat after an advance
	logic [`PSP_BURST_W-1:0] adv_low; // low address bits of that beat
	logic [`PSP_WORD_W-1:0] wr_word; // lanes packed as parity over byte

	////////////////////////////////////////////////////////////////////////
	// decode of the presented control

	assign qualified = !clock_qualifier_n;
	assign selected = !chip_select_one_n && chip_select_two &&
		!chip_select_three_n;
	assign awake = (sleep_state == PSP_AWAKE);
	assign adv_beat = burst_beat + `PSP_BEAT_ONE;

	// next low address bits; both orders stay inside the group of four
	always_comb begin
		if (burst_order == PSP_ORDER_INTERLEAVED) begin
			adv_low = burst_base[`PSP_BURST_W-1:0] ^ adv_beat;
		end else begin
			adv_low = burst_base[`PSP_BURST_W-1:0] + adv_beat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sleep sequencer: sleep_request is taken as synchronous here, the
	// array keeps its contents, only the access logic is parked

	always_comb begin
		next_sleep_state = sleep_state;
		next_sleep_cnt = sleep_cnt;
		case (sleep_state)
			PSP_AWAKE: begin
				if (sleep_request) begin
					next_sleep_state = PSP_ENTERING;
					next_sleep_cnt = `PSP_BEAT_ZERO;
				end
			end
			PSP_ENTERING: begin
				// a request dropped midway still needs the full recovery
				if (!sleep_request) begin
					next_sleep_state = PSP_WAKING;
					next_sleep_cnt = `PSP_BEAT_ZERO;
				end else if (sleep_cnt == `PSP_SLEEP_LAST) begin
					next_sleep_state = PSP_ASLEEP;
				end else begin
					next_sleep_cnt = sleep_cnt + `PSP_BEAT_ONE;
				end
			end
			PSP_ASLEEP: begin
				if (!sleep_request) begin
					next_sleep_state = PSP_WAKING;
					next_sleep_cnt = `PSP_BEAT_ZERO;
				end
			end
			PSP_WAKING: begin
				if (sleep_request) begin
					next_sleep_state = PSP_ENTERING;
					next_sleep_cnt = `PSP_BEAT_ZERO;
				end else if (sleep_cnt == `PSP_SLEEP_LAST) begin
					next_sleep_state = PSP_AWAKE;
				end else begin
					next_sleep_cnt = sleep_cnt + `PSP_BEAT_ONE;
				end
			end
			default: begin
				next_sleep_state = PSP_AWAKE;
				next_sleep_cnt = `PSP_BEAT_ZERO;
			end
		endcase
	end

	// sleep registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sleep_state <= PSP_AWAKE;
			sleep_cnt <= `PSP_BEAT_ZERO;
		end else begin
			sleep_state <= next_sleep_state;
			sleep_cnt <= next_sleep_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// access pipeline: load, advance, deselect, then the write data stage

	always_comb begin
		next_burst_active = burst_active;
		next_burst_write = burst_write;
		next_burst_base = burst_base;
		next_burst_beat = burst_beat;
		next_burst_order = burst_order;
		next_s1_valid = s1_valid;
		next_s1_write = s1_write;
		next_s1_addr = s1_addr;
		next_s1_bw_n = s1_bw_n;
		next_s2_valid = s2_valid;
		next_s2_addr = s2_addr;
		next_s2_bw_n = s2_bw_n;
		next_read_out = read_out;
		if (!awake || sleep_request) begin
			// anything in flight is abandoned on the way into sleep
			next_burst_active = 1'b0;
			next_s1_valid = 1'b0;
			next_s2_valid = 1'b0;
			next_read_out = 1'b0;
		end else if (qualified) begin
			// stage one moves on every counted edge, so a new operation
			// is taken right behind any other one
			next_read_out = s1_valid && !s1_write;
			next_s2_valid = s1_valid && s1_write;
			next_s2_addr = s1_addr;
			next_s2_bw_n = s1_bw_n;
			if (advance_or_load) begin
				// selects and write select ignored while advancing
				next_burst_beat = adv_beat;
				next_s1_valid = burst_active;
				next_s1_write = burst_write;
				next_s1_addr = {burst_base[`PSP_ADDR_W-1:`PSP_BURST_W],
					adv_low};
				next_s1_bw_n = byte_lane_write_n;
			end else if (selected) begin
				next_burst_active = 1'b1;
				next_burst_write = !write_select_n;
				next_burst_base = address;
				next_burst_beat = `PSP_BEAT_ZERO;
				next_burst_order = burst_order_interleaved ?
					PSP_ORDER_INTERLEAVED : PSP_ORDER_LINEAR;
				next_s1_valid = 1'b1;
				next_s1_write = !write_select_n;
				next_s1_addr = address;
				next_s1_bw_n = byte_lane_write_n;
			end else begin
				// a deselect also ends the burst; later advances stay idle
				next_burst_active = 1'b0;
				next_s1_valid = 1'b0;
			end
		end
	end

	// pipeline registers, all captured on the rising edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			burst_active <= 1'b0;
			burst_write <= 1'b0;
			burst_base <= '0;
			burst_beat <= `PSP_BEAT_ZERO;
			burst_order <= PSP_ORDER_LINEAR;
			s1_valid <= 1'b0;
			s1_write <= 1'b0;
			s1_addr <= '0;
			s1_bw_n <= '1;
			s2_valid <= 1'b0;
			s2_addr <= '0;
			s2_bw_n <= '1;
			read_out <= 1'b0;
		end else begin
			burst_active <= next_burst_active;
			burst_write <= next_burst_write;
			burst_base <= next_burst_base;
			burst_beat <= next_burst_beat;
			burst_order <= next_burst_order;
			s1_valid <= next_s1_valid;
			s1_write <= next_s1_write;
			s1_addr <= next_s1_addr;
			s1_bw_n <= next_s1_bw_n;
			s2_valid <= next_s2_valid;
			s2_addr <= next_s2_addr;
			s2_bw_n <= next_s2_bw_n;
			read_out <= next_read_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array access: read from stage one into the output register, write
	// from stage two with the data present at that edge

	genvar i;
	generate
		for (i = 0; i < `PSP_LANES; i = i + 1) begin : g_pack
			assign wr_word[i*`PSP_LANE_W +: `PSP_LANE_W] = {parity_lanes_in[i],
				data_lanes_in[i*`PSP_BYTE_W +: `PSP_BYTE_W]};
			assign data_lanes_out[i*`PSP_BYTE_W +: `PSP_BYTE_W] =
				mem_port.rdata[i*`PSP_LANE_W +: `PSP_BYTE_W];
			assign parity_lanes_out[i] =
				mem_port.rdata[i*`PSP_LANE_W + `PSP_BYTE_W];
		end
	endgenerate

	// a held edge must not disturb the output register or the array
	assign mem_port.rd_en = awake && !sleep_request && qualified &&
		s1_valid && !s1_write;
	assign mem_port.rd_addr = s1_addr;
	assign mem_port.wr_en = awake && !sleep_request && qualified &&
		s2_valid;
	assign mem_port.wr_addr = s2_addr;
	assign mem_port.lane_en = ~s2_bw_n;
	assign mem_port.wdata = wr_word;

	psp_core_mem u_mem (
		.core_clk(core_clk),
		.port(mem_port.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// drivers: output enable acts without the clock; write data phases
	// never have read_out set, so they stay off whatever it does

	assign lanes_oe = read_out && !output_enable_n && awake &&
		!sleep_request;
	assign asleep = (sleep_state == PSP_ASLEEP);

endmodule

`default_nettype wire

// ===== tb/psp_sram_port_checker.sv
// concurrent checks on the pins of the sram port
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module psp_sram_port_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clock_qualifier_n,
	input wire logic advance_or_load,
	input wire logic write_select_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [`PSP_DATA_W-1:0] data_lanes_out,
	input wire logic lanes_oe,
	input wire logic asleep
);
	// all three selects active together
	wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	// edge that the port really counts
	wire take = !clock_qualifier_n;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// no sleep activity lately, so a load is accepted
	sequence awake;
		!sleep_request && !asleep && $past({sleep_request, asleep}) == 2'h0
		&& $past({sleep_request, asleep}, 2) == 2'h0
		&& $past({sleep_request, asleep}, 3) == 2'h0;
	endsequence
	sequence rd_start;
		take && !advance_or_load && sel && write_select_n ##0 awake;
	endsequence
	sequence wr_start;
		take && !advance_or_load && sel && !write_select_n ##0 awake;
	endsequence

	a_read_drives: assert property (rd_start ##1 take |=>
		lanes_oe == (!output_enable_n && !sleep_request))
		else $error("read did not drive the lanes");
	a_deselect_off: assert property (take && !advance_or_load && !sel
		##1 take |=> !lanes_oe) else $error("deselect left lanes driven");
	a_write_tristate: assert property (wr_start ##1 take |=> !lanes_oe)
		else $error("lanes driven in write data phase");
	a_oe_gate: assert property (output_enable_n || sleep_request
		|-> !lanes_oe) else $error("lanes driven while disabled");
	a_stall_data: assert property (clock_qualifier_n
		|=> $stable(data_lanes_out)) else $error("read data moved in stall");
	a_stall_enable: assert property (clock_qualifier_n && !sleep_request
		&& !asleep ##1 (!sleep_request && $stable(output_enable_n)
		&& $stable(asleep)) |-> $stable(lanes_oe))
		else $error("driver state moved in stall");
	a_sleep_slow: assert property ($rose(sleep_request) && !asleep
		|=> !asleep) else $error("sleep entered too soon");
	a_sleep_entry: assert property (sleep_request[*5] |-> asleep)
		else $error("sleep not entered");
	a_sleep_exit: assert property (!sleep_request[*5] |-> !asleep)
		else $error("sleep not left");
endmodule

bind psp_sram_port psp_sram_port_checker psp_sram_port_checker_i (
	.core_clk, .rst, .clock_qualifier_n, .advance_or_load, .write_select_n,
	.chip_select_one_n, .chip_select_two, .chip_select_three_n,
	.output_enable_n, .sleep_request, .data_lanes_out, .lanes_oe, .asleep);

`default_nettype wire

// ===== tb/psp_ctrl_model.sv
// memory controller side of the shared data and parity lanes
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module psp_ctrl_model (
	input wire logic core_clk,
	input wire logic drive,
	input wire logic [`PSP_WORD_W-1:0] wdata,
	input wire logic lanes_oe,
	output logic [`PSP_DATA_W-1:0] data_lanes_in,
	output logic [`PSP_LANES-1:0] parity_lanes_in
);
	logic [`PSP_WORD_W-1:0] last; // value seen on the lanes last cycle
	logic [`PSP_WORD_W-1:0] bus; // what the port samples

	// released lanes show the inverse, so a stale capture is caught
	always_comb bus = (drive && !lanes_oe) ? wdata : ~last;
	always_ff @(posedge core_clk) last <= bus;
	assign data_lanes_in = bus[`PSP_DATA_W-1:0];
	assign parity_lanes_in = bus[`PSP_WORD_W-1:`PSP_DATA_W];
endmodule

`default_nettype wire

// ===== tb/test_pipelined_burst_sram_port.sv
// self-checking bench of the pipelined burst sram port
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module test_pipelined_burst_sram_port;
	logic core_clk = 1'b0, rst = 1'b1, clock_qualifier_n = 1'b0;
	logic advance_or_load = 1'b0, write_select_n = 1'b1, drive = 1'b0;
	logic chip_select_one_n = 1'b1, chip_select_two = 1'b0;
	logic chip_select_three_n = 1'b1, output_enable_n = 1'b0;
	logic burst_order_interleaved = 1'b0, sleep_request = 1'b0;
	logic [3:0] byte_lane_write_n = 4'hf, parity_lanes_in, parity_lanes_out;
	logic [19:0] address = 20'h0;
	logic [35:0] wdata = 36'h0;
	logic [31:0] data_lanes_in, data_lanes_out;
	logic lanes_oe, asleep;
	int failures = 0, tests_run = 0, cycles = 0;
	logic [35:0] bmem [4]; // burst words by low address bits
	typedef struct {logic [19:0] a; logic [3:0] bw; logic [35:0] wd, e;}
		psp_row_t;
	// full, partial, aborted and second-location writes
	psp_row_t rows [5] = '{'{20'h10, 4'h0, 36'h1_1111_1111, 36'h1_1111_1111},
		'{20'h10, 4'ha, 36'hf_2222_2222, 36'h5_1122_1122},
		'{20'h10, 4'hf, 36'h3_3333_3333, 36'h5_1122_1122},
		'{20'h21, 4'h0, 36'ha_bcde_f012, 36'ha_bcde_f012},
		'{20'h21, 4'h6, 36'h0_9999_9999, 36'h2_99de_f099}};

	psp_sram_port psp_sram_port_i (.core_clk, .rst, .clock_qualifier_n,
		.advance_or_load, .write_select_n, .byte_lane_write_n,
		.chip_select_one_n, .chip_select_two, .chip_select_three_n,
		.output_enable_n, .burst_order_interleaved, .sleep_request, .address,
		.data_lanes_in, .parity_lanes_in, .data_lanes_out, .parity_lanes_out,
		.lanes_oe, .asleep);
	psp_ctrl_model psp_ctrl_model_i (.core_clk, .drive, .wdata, .lanes_oe,
		.data_lanes_in, .parity_lanes_in);

	initial forever #10 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////
	task test_done();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// a hung handshake must not stall the run forever
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			failures = failures + 1;
			test_done();
		end
	end
	task check(input logic [35:0] seen, input logic [35:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [35:0] word();
		return {parity_lanes_out, data_lanes_out};
	endfunction
	// one controller cycle, taken by the port at the following edge
	task step(input logic adv, input logic we_n, input logic sel,
		input logic [19:0] a, input logic [3:0] bw, input logic drv,
		input logic [35:0] wd);
		@(posedge core_clk);
		advance_or_load <= adv;
		write_select_n <= we_n;
		chip_select_one_n <= !sel;
		chip_select_two <= sel;
		chip_select_three_n <= !sel;
		address <= a;
		byte_lane_write_n <= bw;
		drive <= drv;
		wdata <= wd;
	endtask
	// single read, then deselect; st freezes the clock after the data
	task rd(input logic [19:0] a, input logic [35:0] exp, input logic st);
		step(1'b0, 1'b1, 1'b1, a, 4'hf, 1'b0, 36'h0);
		step(1'b0, 1'b1, 1'b0, 20'h0, 4'hf, 1'b0, 36'h0);
		@(posedge core_clk);
		clock_qualifier_n <= st;
		#1;
		check(word(), exp);
		check({35'h0, lanes_oe}, 36'h1);
	endtask
	// four beats from low bits 01; advance beats drop selects, flip write
	task burst(input logic wr, input logic ord);
		logic [1:0] b;
		logic [35:0] p;
		for (int k = 0; k < 6; k++) begin
			p = {ord, 3'h3, 28'h0abcdef, 4'(k)};
			step(k > 0 && k < 4, (k == 0) ? !wr : wr, k == 0, 20'h00041, 4'h0,
				wr && k > 1, p);
			if (k == 0) burst_order_interleaved <= ord;
			#1;
			b = ord ? 2'h1 ^ 2'(k - 2) : 2'h1 + 2'(k - 2);
			if (k > 1 && wr) bmem[b] = p;
			else if (k > 1) check(word(), bmem[b]);
		end
		$display("burst write %0d order %0d done", wr, ord);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check({34'h0, lanes_oe, asleep}, 36'h0);
		$display("power-up reset done");
		foreach (rows[i]) begin
			step(1'b0, 1'b0, 1'b1, rows[i].a, rows[i].bw, 1'b0, 36'h0);
			step(1'b0, 1'b1, 1'b0, 20'h0, 4'hf, 1'b0, 36'h0);
			step(1'b0, 1'b1, 1'b0, 20'h0, 4'hf, 1'b1, rows[i].wd);
			rd(rows[i].a, rows[i].e, 1'b0);
		end
		$display("row writes done");
		for (int o = 0; o < 2; o++) begin
			burst(1'b1, o[0]);
			burst(1'b0, !o[0]);
		end
		rd(20'h21, 36'h2_99de_f099, 1'b1);
		repeat (3) @(posedge core_clk);
		#1;
		check(word(), 36'h2_99de_f099);
		check({35'h0, lanes_oe}, 36'h1);
		@(posedge core_clk) output_enable_n <= 1'b1;
		#1;
		check({35'h0, lanes_oe}, 36'h0);
		@(posedge core_clk) output_enable_n <= 1'b0;
		clock_qualifier_n <= 1'b0;
		@(posedge core_clk);
		#1;
		check({35'h0, lanes_oe}, 36'h0);
		$display("stall done");
		// selects are already inactive before the request
		@(posedge core_clk) sleep_request <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		check({34'h0, asleep, lanes_oe}, 36'h2);
		@(posedge core_clk) sleep_request <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		check({35'h0, asleep}, 36'h0);
		rd(20'h10, 36'h5_1122_1122, 1'b0);
		$display("sleep done");
		// reset while a read is held: drivers drop, the array keeps its words
		rd(20'h21, 36'h2_99de_f099, 1'b1);
		@(posedge core_clk) rst <= 1'b1;
		@(posedge core_clk) rst <= 1'b0;
		clock_qualifier_n <= 1'b0;
		#1;
		check({34'h0, lanes_oe, asleep}, 36'h0);
		rd(20'h10, 36'h5_1122_1122, 1'b0);
		$display("mid-run reset done");
		test_done();
	end
endmodule

`default_nettype wire
